//--- rtl/iav_pkg.sv
// Package for the interrupt aggregator vector block.
// Assumes a 32-bit core extension register port and a peripheral bus write port.
package iav_pkg;
  localparam int unsigned NUM_GROUPS   = 24;
  localparam int unsigned NUM_SOURCES  = 32;
  localparam int unsigned FIRST_GROUP  = 8;
  localparam int unsigned PRIO_W       = 3;
  localparam int unsigned BUS_ADDR_W   = 12;
  localparam int unsigned CORE_ADDR_W  = 6;

  localparam logic [11:0] LINE_MASK_OFFSET  = 12'h204;
  localparam logic [11:0] GROUP_GATE_OFFSET = 12'h200;
  localparam logic [31:0] LINE_MASK_RESET   = 32'h00ffff00;
  localparam logic [31:0] LINE_MASK_WMASK   = 32'h00fffff8;
  localparam logic [31:0] GROUP_GATE_RESET  = 32'h00ffff00;
  localparam logic [31:0] GROUP_GATE_WMASK  = 32'h00ffff00;

  localparam logic [5:0]  VECTOR_REG_ADDR    = 6'h38;
  localparam logic [5:0]  THRESHOLD_REG_ADDR = 6'h37;

  localparam int unsigned VECTOR_TABLE_BASE_LSB   = 11;
  localparam int unsigned VECTOR_TABLE_BASE_W     = 13;
  localparam int unsigned GROUP_LSB     = 7;
  localparam int unsigned GROUP_W       = 4;
  localparam int unsigned SOURCE_LSB    = 2;
  localparam int unsigned SOURCE_W      = 5;
  localparam int unsigned SERVED_LSB    = 3;
  localparam int unsigned THRESH_LSB    = 0;
  localparam logic [VECTOR_TABLE_BASE_W-1:0] VECTOR_TABLE_BASE_RESET = 13'h0000;
  localparam logic [PRIO_W-1:0]    BLOCK_LEVEL   = 3'h4;

  typedef struct packed {
    logic                   found;
    logic [GROUP_W-1:0]     group;
    logic [SOURCE_W-1:0]    source;
    logic [PRIO_W-1:0]      prio;
  } iav_sel_t;

  typedef struct packed {
    logic                   rd;
    logic                   wr;
    logic [CORE_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
  } iav_core_req_t;
endpackage

//--- rtl/iav_top.sv
// Interrupt aggregator with vector generation and priority threshold.
// Assumes source lines and priorities are synchronous to i_clk.
// Groups 0..7 have no gate bit, so they never qualify for the vector.
`timescale 1ns/100ps
`default_nettype none
module iav_top
(
  input  wire logic                        i_clk,
  input  wire logic                        i_resetn,
  input  wire logic [iav_pkg::NUM_GROUPS*iav_pkg::NUM_SOURCES-1:0] i_source,
  input  wire logic [iav_pkg::NUM_GROUPS*iav_pkg::NUM_SOURCES*3-1:0] i_prio,
  input  wire logic [iav_pkg::NUM_GROUPS-1:0] i_agg_line,
  input  wire logic                        i_bus_wr,
  input  wire logic [iav_pkg::BUS_ADDR_W-1:0] i_bus_addr,
  input  wire logic [31:0]                 i_bus_wdata,
  output logic      [31:0]                 o_bus_rdata,
  input  wire iav_pkg::iav_core_req_t      i_core_req,
  output logic      [31:0]                 o_core_rdata,
  output logic      [iav_pkg::NUM_GROUPS-1:0] o_core_irq
);
  logic [31:0]                     line_mask_reg;
  logic [31:0]                     group_gate_reg;
  logic [iav_pkg::VECTOR_TABLE_BASE_W-1:0]   vector_table_base_reg;
  logic [iav_pkg::PRIO_W-1:0]      thresh_reg;
  logic [iav_pkg::PRIO_W-1:0]      served_reg;
  iav_pkg::iav_sel_t               sel;
  logic [31:0]                     vector_value;
  logic [31:0]                     thresh_value;
  logic [iav_pkg::NUM_GROUPS-1:0]  grp_found;
  logic [iav_pkg::SOURCE_W-1:0]    grp_src [iav_pkg::NUM_GROUPS];
  logic [iav_pkg::PRIO_W-1:0]      grp_prio [iav_pkg::NUM_GROUPS];
  logic                            level_blocked;
  logic [iav_pkg::NUM_GROUPS-1:0]  grp_open;
  logic                            vec_read;

  function automatic logic bus_hit(input logic [iav_pkg::BUS_ADDR_W-1:0] a,
                                   input logic [11:0] o);
    bus_hit = a == o;
  endfunction

  function automatic logic core_hit(input iav_pkg::iav_core_req_t r,
                                    input logic [5:0] a);
    core_hit = r.addr == a;
  endfunction

  // Peripheral bus enable registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      line_mask_reg  <= iav_pkg::LINE_MASK_RESET;
      group_gate_reg <= iav_pkg::GROUP_GATE_RESET;
    end
    else if (i_bus_wr)
    begin
      if (bus_hit(i_bus_addr, iav_pkg::LINE_MASK_OFFSET))
      begin
        line_mask_reg <= i_bus_wdata & iav_pkg::LINE_MASK_WMASK;
      end
      else if (bus_hit(i_bus_addr, iav_pkg::GROUP_GATE_OFFSET))
      begin
        group_gate_reg <= i_bus_wdata & iav_pkg::GROUP_GATE_WMASK;
      end
    end
  end

  always_comb
  begin
    if (bus_hit(i_bus_addr, iav_pkg::LINE_MASK_OFFSET))
    begin
      o_bus_rdata = line_mask_reg;
    end
    else if (bus_hit(i_bus_addr, iav_pkg::GROUP_GATE_OFFSET))
    begin
      o_bus_rdata = group_gate_reg;
    end
    else
    begin
      o_bus_rdata = 32'h00000000;
    end
  end

  // Line gating toward the core
  assign o_core_irq = i_agg_line & line_mask_reg[iav_pkg::NUM_GROUPS-1:0];

  // Threshold of four or more shuts every group off
  assign level_blocked = thresh_reg >= iav_pkg::BLOCK_LEVEL;
  assign grp_open      = group_gate_reg[iav_pkg::NUM_GROUPS-1:0]
                         & ~{iav_pkg::NUM_GROUPS{level_blocked}};

  // Per-group search: highest bit number that qualifies
  genvar g;
  generate
    for (g = 0; g < iav_pkg::NUM_GROUPS; g++)
    begin : g_grp
      always_comb
      begin
        logic [iav_pkg::PRIO_W-1:0] p;
        p = '0;
        grp_found[g] = 1'b0;
        grp_src[g]   = '0;
        grp_prio[g]  = '0;
        for (int s = 0; s < iav_pkg::NUM_SOURCES; s++)
        begin
          p = i_prio[(g*iav_pkg::NUM_SOURCES+s)*iav_pkg::PRIO_W +:
                     iav_pkg::PRIO_W];
          // A later bit overwrites an earlier one, so the top bit wins
          if (i_source[g*iav_pkg::NUM_SOURCES+s] && grp_open[g]
              && p >= thresh_reg)
          begin
            grp_found[g] = 1'b1;
            grp_src[g]   = iav_pkg::SOURCE_W'(s);
            grp_prio[g]  = p;
          end
        end
      end
    end
  endgenerate

  // Group arbitration: highest index wins, recomputed continuously
  always_comb
  begin
    sel = '0;
    // Field counts from the first gated group, so 16 groups fit four bits
    for (int i = int'(iav_pkg::FIRST_GROUP); i < iav_pkg::NUM_GROUPS; i++)
    begin
      if (grp_found[i])
      begin
        sel.found  = 1'b1;
        sel.group  = iav_pkg::GROUP_W'(i - int'(iav_pkg::FIRST_GROUP));
        sel.source = grp_src[i];
        sel.prio   = grp_prio[i];
      end
    end
  end

  // Vector: base, group, source concatenated, word aligned
  always_comb
  begin
    vector_value = '0;
    vector_value[iav_pkg::VECTOR_TABLE_BASE_LSB +: iav_pkg::VECTOR_TABLE_BASE_W] =
      vector_table_base_reg;
    vector_value[iav_pkg::GROUP_LSB +: iav_pkg::GROUP_W] = sel.group;
    vector_value[iav_pkg::SOURCE_LSB +: iav_pkg::SOURCE_W] = sel.source;
  end

  always_comb
  begin
    thresh_value = '0;
    thresh_value[iav_pkg::SERVED_LSB +: iav_pkg::PRIO_W] = served_reg;
    thresh_value[iav_pkg::THRESH_LSB +: iav_pkg::PRIO_W] = thresh_reg;
  end

  // Core extension register writes; group and source never written
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      vector_table_base_reg <= iav_pkg::VECTOR_TABLE_BASE_RESET;
      thresh_reg  <= '0;
    end
    else if (i_core_req.wr)
    begin
      if (core_hit(i_core_req, iav_pkg::VECTOR_REG_ADDR))
      begin
        vector_table_base_reg <= i_core_req.wdata[iav_pkg::VECTOR_TABLE_BASE_LSB +:
                                        iav_pkg::VECTOR_TABLE_BASE_W];
      end
      else if (core_hit(i_core_req, iav_pkg::THRESHOLD_REG_ADDR))
      begin
        thresh_reg <= i_core_req.wdata[iav_pkg::THRESH_LSB +:
                                       iav_pkg::PRIO_W];
      end
    end
  end

  assign vec_read = i_core_req.rd
                    && core_hit(i_core_req, iav_pkg::VECTOR_REG_ADDR);

  // Served level loads on every vector read
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      served_reg <= '0;
    end
    else if (vec_read)
    begin
      served_reg <= sel.prio + 3'h1;
    end
  end

  always_comb
  begin
    if (core_hit(i_core_req, iav_pkg::VECTOR_REG_ADDR))
    begin
      o_core_rdata = vector_value;
    end
    else if (core_hit(i_core_req, iav_pkg::THRESHOLD_REG_ADDR))
    begin
      o_core_rdata = thresh_value;
    end
    else
    begin
      o_core_rdata = 32'h00000000;
    end
  end
endmodule
`default_nettype wire

//--- sim/iav_core_model.sv
// Core model issuing extension register reads and writes.
// Assumes callers enter just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module iav_core_model (
  input  wire logic              i_clk,
  input  wire logic [31:0]       i_rdata,
  output var iav_pkg::iav_core_req_t o_req
);
  initial o_req = '0;
  task automatic acc(input logic r, input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    o_req = '{r, w, a, d};
    @(posedge i_clk);
    q = i_rdata;
    #1 o_req = '{1'b0, 1'b0, ~a, ~d};
    @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

//--- sim/iav_properties.sv
// Checker for the interrupt aggregator vector block.
// Assumes it is bound to iav_top and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module iav_properties (
  input wire logic                  i_clk,
  input wire logic                  i_resetn,
  input wire logic [2303:0]         i_prio,
  input wire logic [23:0]           i_agg_line,
  input wire logic                  i_bus_wr,
  input wire logic [11:0]           i_bus_addr,
  input wire logic [31:0]           i_bus_wdata,
  input wire logic [31:0]           o_bus_rdata,
  input wire iav_pkg::iav_core_req_t i_core_req,
  input wire logic [31:0]           o_core_rdata,
  input wire logic [23:0]           o_core_irq
);
  logic [2:0]  lvl_reg;
  logic [2:0]  thr_reg;
  logic [12:0] vt_reg;
  wire  [5:0]  ca = i_core_req.addr;
  wire  [31:0] wd = i_core_req.wdata;
  wire  [31:0] rd = o_core_rdata;
  wire         cw = i_core_req.wr;
  wire         rdv = i_core_req.rd && ca == 6'h38;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Level the served field should take after each vector read
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      lvl_reg <= 3'h0;
    else if (rdv)
      lvl_reg <= i_prio[{rd[10:7] + 5'h08, rd[6:2]} * 3 +: 3] + 3'h1;
  // Threshold and base fields as last written by the core
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      thr_reg <= 3'h0;
      vt_reg  <= 13'h0;
    end
    else if (cw && ca == 6'h37)
      thr_reg <= wd[2:0];
    else if (cw && ca == 6'h38)
      vt_reg <= wd[23:11];
  sequence s_vread;
    rdv;
  endsequence
  sequence s_look;
    ca == 6'h37;
  endsequence
  AST_SERVED: assert property (s_vread ##2 s_look |-> rd[5:3] == lvl_reg)
    else $error("bad served level");
  AST_SERVED_HOLD: assert property (s_look |-> rd[5:3] == lvl_reg)
    else $error("served level not held");
  AST_IRQ_GATE: assert property ((o_core_irq & ~i_agg_line) == 24'h0
    && o_core_irq[2:0] == 3'h0) else $error("bad irq");
  AST_VEC_ZERO: assert property (ca == 6'h38 |-> rd[31:24] == 8'h0
    && rd[1:0] == 2'h0) else $error("bad vector pad");
  AST_THR_ZERO: assert property (ca == 6'h37 |-> rd[31:6] == 26'h0)
    else $error("bad level pad");
  AST_BLOCK: assert property (rdv && thr_reg[2] |->
    rd[10:2] == 9'h0) else $error("not blocked");
  AST_VT_WRITE: assert property (ca == 6'h38 |->
    rd[23:11] == vt_reg) else $error("bad base");
  AST_THR_WRITE: assert property (s_look |->
    rd[2:0] == thr_reg) else $error("bad threshold");
  AST_MASK_WRITE: assert property (i_bus_wr && i_bus_addr == 12'h204
    |=> i_bus_addr != 12'h204 || o_bus_rdata == ($past(i_bus_wdata)
    & 32'h00fffff8)) else $error("bad mask");
endmodule
bind iav_top iav_properties u_prop (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_prio(i_prio), .i_agg_line(i_agg_line), .i_bus_wr(i_bus_wr),
  .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
  .o_bus_rdata(o_bus_rdata), .i_core_req(i_core_req),
  .o_core_rdata(o_core_rdata), .o_core_irq(o_core_irq));
`default_nettype wire

//--- sim/iav_top_tb.sv
// Self-checking bench for the interrupt aggregator vector block.
// Assumes a 125 MHz clock and the core model beside it.
`timescale 1ns/100ps
`default_nettype none
module iav_top_tb;
  logic          clk;
  logic          rstn;
  logic          bwr;
  logic [767:0]  src;
  logic [2303:0] pri;
  logic [23:0]   agg;
  logic [23:0]   irq;
  logic [11:0]   badr;
  logic [31:0]   bwd;
  logic [31:0]   brd;
  logic [31:0]   crd;
  logic [31:0]   q;
  logic [31:0]   rs;
  int            errors;
  int            total_checks;
  iav_pkg::iav_core_req_t req;
  iav_top dut (.i_clk(clk), .i_resetn(rstn), .i_source(src), .i_prio(pri),
    .i_agg_line(agg), .i_bus_wr(bwr), .i_bus_addr(badr), .i_bus_wdata(bwd),
    .o_bus_rdata(brd), .i_core_req(req), .o_core_rdata(crd),
    .o_core_irq(irq));
  iav_core_model core (.i_clk(clk), .i_rdata(crd), .o_req(req));
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bw(input logic [11:0] a, input logic [31:0] d);
    badr = a;
    bwd = d;
    bwr = 1;
    @(posedge clk);
    #1 bwr = 0;
    @(posedge clk);
    #1;
  endtask
  task automatic vt(input logic [2:0] t, input logic [3:0] g,
                    input logic [4:0] s, input logic [2:0] lv);
    core.acc(0, 1, 6'h37, {29'h0, t}, q);
    core.acc(1, 0, 6'h38, 0, q);
    chk("vector", {8'h0, 13'h1fff, g, s, 2'h0}, q);
    core.acc(1, 0, 6'h37, 0, q);
    chk("level", {26'h0, lv, t}, q);
  endtask
  task final_report;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #50000 errors++;
    final_report;
  end
  initial
  begin
    {rstn, bwr, badr, bwd, src, pri, agg} = '0;
    rs = 32'hecfe;
    repeat (8) @(posedge clk);
    #1 rstn = 1;
    badr = 12'h204;
    @(negedge clk);
    chk("mask rst", 32'h00ffff00, brd);
    @(posedge clk);
    #1 badr = 12'h200;
    @(negedge clk);
    chk("gate rst", 32'h00ffff00, brd);
    @(posedge clk);
    #1 badr = 12'h208;
    @(negedge clk);
    chk("unmapped", 0, brd);
    @(posedge clk);
    #1 core.acc(1, 0, 6'h37, 0, q);
    chk("level rst", 0, q);
    core.acc(1, 0, 6'h38, 0, q);
    chk("vector rst", 0, q);
    core.acc(0, 1, 6'h38, 32'hffffffff, q);
    {src[265], src[259], src[289]} = 3'h7;
    {pri[795+:3], pri[777+:3], pri[867+:3]} = {3'h1, 3'h2, 3'h3};
    vt(7, 0, 0, 1);
    vt(4, 0, 0, 1);
    vt(0, 1, 1, 4);
    vt(3, 1, 1, 4);
    bw(12'h200, 32'h00fffd00);
    vt(0, 0, 9, 2);
    vt(2, 0, 3, 3);
    repeat (32)
    begin
      rs = xs(rs);
      agg = rs[31:8];
      bw(12'h204, rs);
      chk("irq", {8'h0, agg & rs[23:0] & 24'hfffff8}, {8'h0, irq});
      chk("mask", rs & 32'h00fffff8, brd);
    end
    final_report;
  end
endmodule
`default_nettype wire
